// file: bench/chtc_mem_model.sv
`default_nettype none
module chtc_mem_model (
   input  wire logic       clk,
   input  wire logic       rst_b,
   input  wire logic       launch,
   input  wire logic       edit,
   input  wire logic       store,
   input  wire logic       fill,
   input  wire logic [9:0] cur,
   input  wire logic [9:0] ma,
   input  wire logic [5:0] dreg,
   input  wire logic [5:0] wdat,
   output logic            ph1,
   output logic            ph4
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [5:0] mem_q [0:1023];
   logic [3:0] step_r;
   initial begin
      for (int i = 0; i < 1024; i++)
         mem_q[i] = 6'h00;
   end
   // twelve steps a cycle; slow enough for the synchronised phases
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         step_r <= 4'h0;
         ph1 <= 1'b0;
         ph4 <= 1'b0;
      end else begin
         ph1 <= step_r == 4'h1;
         ph4 <= step_r == 4'h5;
         if (step_r != 4'h0 || launch)
            step_r <= (step_r == 4'hb) ? 4'h0 : step_r + 4'h1;
         if (step_r == 4'h6 && fill)
            mem_q[ma] <= wdat;
         else if (step_r == 4'h6 && edit && store)
            mem_q[cur] <= dreg;
      end
   end
endmodule
`default_nettype wire

// file: bench/chtc_sva.sv
`include "chtc_regs.vh"
`default_nettype none
module chtc_sva (
   input wire logic       MCLK,
   input wire logic       RST_B,
   input wire logic       MEM_PHASE_ONE,
   input wire logic       MEM_PHASE_FOUR,
   input wire logic [9:0] CURSOR_ADDR,
   input wire logic [9:0] MEM_ADDR,
   input wire logic       ADDR_FROM_COUNTER,
   input wire logic       MEMORY_CYCLE_LAUNCH,
   input wire logic [5:0] MEMORY_WRITE_DATA_LINES,
   input wire logic       EDIT_MEMORY_REQUEST,
   input wire logic       DISPLAY_REG_TO_MEMORY,
   input wire logic [5:0] DISPLAY_REG,
   input wire logic       INSERT_EDIT_FLAG,
   input wire logic       KEYBOARD_BUSY_FLAG
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge MCLK);
   endclocking
   default disable iff (!RST_B);
   wire clr_edit = EDIT_MEMORY_REQUEST && !INSERT_EDIT_FLAG;
   wire poc_old = ADDR_FROM_COUNTER;
   sequence s_cur_clr;
      !poc_old && $changed(CURSOR_ADDR) && CURSOR_ADDR == `CHTC_CLEARED_CNT;
   endsequence
   sequence s_clr_ph1;
      clr_edit && $rose(MEM_PHASE_ONE);
   endsequence
   chk_poc_launch: assert property (poc_old |-> MEMORY_CYCLE_LAUNCH)
      else $error("no cycle launch in power-up clear");
   chk_poc_count: assert property (
      poc_old && $past(poc_old) && $changed(MEM_ADDR)
      |-> MEM_ADDR == $past(MEM_ADDR) + 10'h1)
      else $error("power-up address not counting by one");
   chk_poc_fill: assert property (
      poc_old && MEM_ADDR[0] && MEM_ADDR[2]
      |-> ##[0:1] MEMORY_WRITE_DATA_LINES == `CHTC_CODE_ES)
      else $error("end code missing on write lines");
   chk_idle_base: assert property (
      !poc_old && !$past(poc_old) && !clr_edit && !INSERT_EDIT_FLAG
      |-> MEM_ADDR[7:0] == 8'h05)
      else $error("idle address not at base count");
   chk_cur_xfer: assert property (s_cur_clr |=> CURSOR_ADDR == MEM_ADDR)
      else $error("cursor not loaded from address register");
   chk_es_latch: assert property (
      s_clr_ph1 |-> ##3 DISPLAY_REG == `CHTC_CODE_ES)
      else $error("end code not latched at phase one");
   chk_edit_end: assert property (
      clr_edit && $rose(MEM_PHASE_FOUR) |-> ##3 !EDIT_MEMORY_REQUEST)
      else $error("edit request not ended at phase four");
   chk_write_gate: assert property (DISPLAY_REG_TO_MEMORY)
      else $error("display register not gated to memory");
   chk_busy_free: assert property (
      $rose(EDIT_MEMORY_REQUEST) && !INSERT_EDIT_FLAG
      |-> ##[0:3] !KEYBOARD_BUSY_FLAG)
      else $error("keyboard lock not released on clear");
   chk_launch_edit: assert property (
      !poc_old && !$past(poc_old)
      |-> MEMORY_CYCLE_LAUNCH == $past(EDIT_MEMORY_REQUEST))
      else $error("launch differs from edit request");
endmodule
bind chtc_ctrl chtc_sva chk_u (
   .MCLK(MCLK), .RST_B(RST_B), .MEM_PHASE_ONE(MEM_PHASE_ONE),
   .MEM_PHASE_FOUR(MEM_PHASE_FOUR), .CURSOR_ADDR(CURSOR_ADDR),
   .MEM_ADDR(MEM_ADDR), .ADDR_FROM_COUNTER(ADDR_FROM_COUNTER),
   .MEMORY_CYCLE_LAUNCH(MEMORY_CYCLE_LAUNCH),
   .MEMORY_WRITE_DATA_LINES(MEMORY_WRITE_DATA_LINES),
   .EDIT_MEMORY_REQUEST(EDIT_MEMORY_REQUEST),
   .DISPLAY_REG_TO_MEMORY(DISPLAY_REG_TO_MEMORY), .DISPLAY_REG(DISPLAY_REG),
   .INSERT_EDIT_FLAG(INSERT_EDIT_FLAG), .KEYBOARD_BUSY_FLAG(KEYBOARD_BUSY_FLAG));
`default_nettype wire

// file: bench/cursor_home_clear_tab_ctrl_test.sv
`include "chtc_regs.vh"
`default_nettype none
module cursor_home_clear_tab_ctrl_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, rst_b, av_rd, av_wr, av_wait, key_stb, cur_last, fetch;
   logic        disp_vld, ph1, ph4, afc, launch, edit, d2m, ins, jump, busy;
   logic        edit_seen, jump_seen;
   logic [3:0]  av_addr;
   logic [5:0]  disp_code, wdat, dreg;
   logic [6:0]  hpos;
   logic [9:0]  cursor, maddr;
   logic [31:0] av_wd, av_rdata, q, seed;
   logic [31:0] exp_q[$], msk_q[$];
   int          n_fail, compares, cyc;
   chtc_ctrl #(.POC_CYCLES(16)) dut_u (
      .MCLK(clk), .RST_B(rst_b), .AVS_ADDRESS(av_addr), .AVS_READ(av_rd),
      .AVS_WRITE(av_wr), .AVS_WRITEDATA(av_wd), .AVS_READDATA(av_rdata),
      .AVS_WAITREQUEST(av_wait), .KEY_STROBE(key_stb),
      .MEM_PHASE_ONE(ph1), .MEM_PHASE_FOUR(ph4),
      .CURSOR_LAST_PHASE(cur_last), .FETCH_PULSE(fetch),
      .DISP_READ_VALID(disp_vld), .DISP_READ_CODE(disp_code),
      .HORIZ_POS(hpos), .CURSOR_ADDR(cursor), .MEM_ADDR(maddr),
      .ADDR_FROM_COUNTER(afc), .MEMORY_CYCLE_LAUNCH(launch),
      .MEMORY_WRITE_DATA_LINES(wdat), .EDIT_MEMORY_REQUEST(edit),
      .DISPLAY_REG_TO_MEMORY(d2m), .DISPLAY_REG(dreg),
      .INSERT_EDIT_FLAG(ins), .HORIZONTAL_JUMP_EIGHT(jump),
      .KEYBOARD_BUSY_FLAG(busy));
   chtc_mem_model mem_u (
      .clk(clk), .rst_b(rst_b), .launch(launch), .edit(edit), .store(d2m),
      .fill(afc), .cur(cursor), .ma(maddr), .dreg(dreg), .wdat(wdat),
      .ph1(ph1), .ph4(ph4));
   always #5 clk = ~clk;
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic end_sim;
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic xfer(input logic [3:0] a, input logic w,
                       input logic [31:0] d, e, m);
      av_addr <= a;
      av_wr <= w;
      av_rd <= !w;
      av_wd <= d;
      if (!w) begin
         exp_q.push_back(e);
         msk_q.push_back(m);
      end
      do @(posedge clk); while (av_wait !== 1'b0);
      q = av_rdata;
      av_rd <= 1'b0;
      av_wr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e, m);
      xfer(a, 1'b0, 32'h0, e, m);
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      xfer(a, 1'b1, d, 32'h0, 32'h0);
   endtask
   task automatic poc_wait;
      do rd(`CHTC_STAT_OFS, 32'h0, 32'h0); while (q[0] !== 1'b0);
   endtask
   task automatic key(input logic [31:0] c);
      wr(`CHTC_CTRL_OFS, c);
      key_stb <= 1'b1;
      repeat (4) @(posedge clk);
      key_stb <= 1'b0;
      repeat (12) @(posedge clk);
   endtask
   task automatic pulse_last;
      cur_last <= 1'b1;
      repeat (2) @(posedge clk);
      cur_last <= 1'b0;
      repeat (6) @(posedge clk);
   endtask
   task automatic pulse_fetch;
      fetch <= 1'b1;
      repeat (2) @(posedge clk);
      fetch <= 1'b0;
      repeat (6) @(posedge clk);
   endtask
   task automatic show(input logic [5:0] c);
      disp_code <= c;
      disp_vld <= 1'b1;
      @(posedge clk);
      disp_vld <= 1'b0;
      repeat (4) @(posedge clk);
   endtask
   // read answers checked in request order
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (edit === 1'b1)
         edit_seen <= 1'b1;
      if (jump === 1'b1)
         jump_seen <= 1'b1;
      if (av_rd === 1'b1 && av_wait === 1'b0 && exp_q.size() > 0)
         chk(av_rdata & msk_q.pop_front(), exp_q.pop_front());
      if (cyc == 20000) begin
         n_fail++;
         end_sim();
      end
   end
   initial begin
      {clk, rst_b, av_rd, av_wr, key_stb, cur_last, disp_vld, fetch} = 8'h00;
      {edit_seen, jump_seen, av_addr, hpos, disp_code} = 19'h0;
      av_wd = 32'h0;
      seed = 32'h6a5c;
      n_fail = 0;
      compares = 0;
      cyc = 0;
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      poc_wait();
      rd(`CHTC_MADDR_OFS, 32'h5, 32'h3ff);
      rd(4'h2, 32'h0, 32'hffffffff);
      wr(`CHTC_STAT_OFS, 32'h7f);
      rd(`CHTC_STAT_OFS, 32'h0, 32'h1);
      for (int m = 0; m < 4; m++) begin
         key({22'h0, m[1:0], 8'h01});
         rd(`CHTC_CURSOR_OFS, 32'h5 + 32'h100 * m, 32'h3ff);
         rd(`CHTC_MADDR_OFS, 32'h5 + 32'h100 * m, 32'h3ff);
      end
      key(32'h202);
      while (edit !== 1'b0)
         @(posedge clk);
      chk({26'h0, mem_u.mem_q[10'h205]}, {26'h0, `CHTC_CODE_ES});
      chk({31'h0, edit_seen}, 32'h1);
      rd(`CHTC_STAT_OFS, 32'h0, 32'h6);
      rd(`CHTC_CURSOR_OFS, 32'h205, 32'h3ff);
      wr(`CHTC_CTRL_OFS, 32'h4);
      hpos <= 7'h10;
      pulse_last();
      rd(`CHTC_STAT_OFS, 32'h0, 32'h8);
      wr(`CHTC_CTRL_OFS, 32'h4);
      seed = lfsr(seed);
      hpos <= {1'b0, seed[5:3], seed[2:0] | 3'h1};
      pulse_last();
      rd(`CHTC_STAT_OFS, 32'h8, 32'h8);
      hpos <= 7'h18;
      disp_code <= {1'b0, seed[12:8]};
      disp_vld <= 1'b1;
      repeat (4) @(posedge clk);
      disp_vld <= 1'b0;
      repeat (4) @(posedge clk);
      rd(`CHTC_CURSOR_OFS, 32'h5, 32'h3ff);
      show(`CHTC_CODE_FT);
      chk({31'h0, jump_seen}, 32'h1);
      wr(`CHTC_CTRL_OFS, 32'h4);
      hpos <= 7'h11;
      pulse_last();
      show(`CHTC_CODE_ES);
      rd(`CHTC_STAT_OFS, 32'h10, 32'h18);
      pulse_fetch();
      while (edit !== 1'b0)
         @(posedge clk);
      chk({26'h0, mem_u.mem_q[10'h5]}, {26'h0, `CHTC_CODE_FT});
      rd(`CHTC_CURSOR_OFS, 32'h6, 32'h3ff);
      wr(`CHTC_CTRL_OFS, 32'h4);
      hpos <= 7'h4a;
      pulse_last();
      pulse_fetch();
      rd(`CHTC_STAT_OFS, 32'h60, 32'h60);
      show(`CHTC_CODE_ES);
      pulse_fetch();
      while (edit !== 1'b0)
         @(posedge clk);
      chk({26'h0, mem_u.mem_q[10'h6]}, {26'h0, `CHTC_CODE_NL});
      wr(`CHTC_CTRL_OFS, 32'h8);
      rd(`CHTC_STAT_OFS, 32'h0, 32'h1);
      wr(`CHTC_CTRL_OFS, 32'h18);
      rd(`CHTC_STAT_OFS, 32'h1, 32'h1);
      poc_wait();
      rd(`CHTC_MADDR_OFS, 32'h5, 32'h3ff);
      end_sim();
   end
endmodule
`default_nettype wire

// file: rtl/chtc_ctrl.v
// Notes on behaviour
// - home loads monitor base count into cursor
// - reset cursor, then transfer address to cursor
// - idle address register rests at base count
// - clear stores end-screen at first position
// - clear sets end-screen and one-cycle edit flags
// - clear releases keyboard busy lock
// - end-screen on input lines, latched phase one
// - write phases store; phase four ends edit
// - power-up clear presets the flags and cursor, counts the address on; mon_r is kept, allow_r still takes control writes
// - clear-allow plus break asserts power-up clear
// - power-up clear launches memory cycles continuously
// - power-up addresses from counter, increments phase four
// - address bits zero and two force end-screen
// - fill stops when power-up clear ends
// - tab advances cursor to multiple of eight
// - tab at cursor phase sets compare flag
// - compare hit transfers address to cursor
// - end or newline first sets insert flag
// - insert edit writes tab, pushes end down
// - displayed tab jumps counter to next eight
// - past seventy-two insert newline instead
// - newline flag arms end detection then insert
`include "chtc_regs.vh"
`default_nettype none
module chtc_ctrl #(
   parameter POC_CYCLES = `CHTC_POC_CYCLES
) (
   input  wire        MCLK,
   input  wire        RST_B,
   input  wire [3:0]  AVS_ADDRESS,
   input  wire        AVS_READ,
   input  wire        AVS_WRITE,
   input  wire [31:0] AVS_WRITEDATA,
   output reg  [31:0] AVS_READDATA,
   output reg         AVS_WAITREQUEST,
   input  wire        KEY_STROBE,
   input  wire        MEM_PHASE_ONE,
   input  wire        MEM_PHASE_FOUR,
   input  wire        CURSOR_LAST_PHASE,
   input  wire        FETCH_PULSE,
   input  wire        DISP_READ_VALID,
   input  wire [5:0]  DISP_READ_CODE,
   input  wire [6:0]  HORIZ_POS,
   output reg  [9:0]  CURSOR_ADDR,
   output reg  [9:0]  MEM_ADDR,
   output reg         ADDR_FROM_COUNTER,
   output reg         MEMORY_CYCLE_LAUNCH,
   output reg  [5:0]  MEMORY_WRITE_DATA_LINES,
   output reg         EDIT_MEMORY_REQUEST,
   output reg         DISPLAY_REG_TO_MEMORY,
   output reg  [5:0]  DISPLAY_REG,
   output reg         INSERT_EDIT_FLAG,
   output reg         HORIZONTAL_JUMP_EIGHT,
   output reg         KEYBOARD_BUSY_FLAG
);
   localparam ST_IDLE = 3'b001;
   localparam ST_XFER = 3'b010;
   localparam ST_DONE = 3'b100;

   reg [19:0] poc_cnt_r;
   reg        poc_r;
   reg [1:0]  ph1_s;
   reg [1:0]  ph4_s;
   reg [1:0]  cur_s;
   reg [1:0]  fet_s;
   reg [1:0]  stb_s;
   reg [1:0]  val_s;
   reg [5:0]  code_s0;
   reg [5:0]  code_s1;
   reg [6:0]  hp_s0;
   reg [6:0]  hp_s1;
   reg [1:0]  mon_r;
   reg        allow_r;
   reg        home_req_r;
   reg        clr_req_r;
   reg        tab_req_r;
   reg        brk_r;
   reg [2:0]  xfer_st_r;
   reg        end_screen_flag_r;
   reg        one_cycle_edit_r;
   reg        tab_compare_r;
   reg        insert_pending_r;
   reg        newline_insert_r;
   reg        arm_end_detect_r;
   reg        edit_tab_code_r;
   reg        ph4_d_r;
   reg        fet_d_r;
   reg        stb_d_r;
   reg        cur_d_r;
   reg        ph1_d_r;

   wire [9:0] base_cnt  = `CHTC_CLEARED_CNT + {mon_r, 8'h00};
   wire       ph1_rise  = ph1_s[1] & ~ph1_d_r;
   wire       ph4_rise  = ph4_s[1] & ~ph4_d_r;
   wire       fet_rise  = fet_s[1] & ~fet_d_r;
   wire       stb_rise  = stb_s[1] & ~stb_d_r;
   wire       cur_rise  = cur_s[1] & ~cur_d_r;
   wire       hp_mod8   = (hp_s1[2:0] == 3'h0);
   wire       rd_end    = val_s[1] & (code_s1 == `CHTC_CODE_ES);
   wire       rd_nl     = val_s[1] & (code_s1 == `CHTC_CODE_NL);
   wire       rd_ft     = val_s[1] & (code_s1 == `CHTC_CODE_FT);
   wire       bus_hit   = (AVS_READ | AVS_WRITE) & AVS_WAITREQUEST;
   wire       ctrl_wr   = AVS_WRITE & ~AVS_WAITREQUEST &
                          (AVS_ADDRESS == `CHTC_CTRL_OFS);
   wire       home_go   = home_req_r & stb_rise;
   wire       clr_go    = clr_req_r & stb_rise;
   wire       hit_tab   = tab_compare_r & hp_mod8 & val_s[1];
   wire       hit_stop  = tab_compare_r & (rd_end | rd_nl);
   wire       tab_set   = tab_req_r & cur_rise;
   wire [6:0] hp_next8  = {hp_s1[6:3] + 4'h1, 3'h0};
   wire [9:0] ma_step   = ph4_rise ? MEM_ADDR + 10'h001 : MEM_ADDR;

   // two-flop synchronisers for all pin inputs
   always @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         ph1_s   <= 2'b00;
         ph4_s   <= 2'b00;
         cur_s   <= 2'b00;
         fet_s   <= 2'b00;
         stb_s   <= 2'b00;
         val_s   <= 2'b00;
         code_s0 <= 6'h00;
         code_s1 <= 6'h00;
         hp_s0   <= 7'h00;
         hp_s1   <= 7'h00;
         ph1_d_r <= 1'b0;
         ph4_d_r <= 1'b0;
         fet_d_r <= 1'b0;
         stb_d_r <= 1'b0;
         cur_d_r <= 1'b0;
      end else begin
         ph1_s   <= {ph1_s[0], MEM_PHASE_ONE};
         ph4_s   <= {ph4_s[0], MEM_PHASE_FOUR};
         cur_s   <= {cur_s[0], CURSOR_LAST_PHASE};
         fet_s   <= {fet_s[0], FETCH_PULSE};
         stb_s   <= {stb_s[0], KEY_STROBE};
         val_s   <= {val_s[0], DISP_READ_VALID};
         code_s0 <= DISP_READ_CODE;
         code_s1 <= code_s0;
         hp_s0   <= HORIZ_POS;
         hp_s1   <= hp_s0;
         ph1_d_r <= ph1_s[1];
         ph4_d_r <= ph4_s[1];
         fet_d_r <= fet_s[1];
         stb_d_r <= stb_s[1];
         cur_d_r <= cur_s[1];
      end
   end

   // power-up clear timer; break with allow restarts it
   always @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         poc_cnt_r <= 20'h00000;
         poc_r     <= 1'b1;
      end else if (brk_r & allow_r) begin
         poc_cnt_r <= 20'h00000;
         poc_r     <= 1'b1;
      end else if (poc_r) begin
         if (poc_cnt_r == POC_CYCLES[19:0] - 20'h00001) begin
            poc_r <= 1'b0;
         end
         poc_cnt_r <= poc_cnt_r + 20'h00001;
      end
   end

   // register bus slave, one wait state per access
   always @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         AVS_WAITREQUEST <= 1'b1;
         AVS_READDATA    <= 32'h00000000;
      end else if (bus_hit) begin
         AVS_WAITREQUEST <= 1'b0;
         case (AVS_ADDRESS)
            `CHTC_CTRL_OFS:
               AVS_READDATA <= {22'h0, mon_r, 4'h0, allow_r, 3'h0};
            `CHTC_STAT_OFS:
               AVS_READDATA <= {25'h0, arm_end_detect_r,
                                newline_insert_r, insert_pending_r,
                                tab_compare_r, one_cycle_edit_r,
                                KEYBOARD_BUSY_FLAG, poc_r};
            `CHTC_CURSOR_OFS:
               AVS_READDATA <= {22'h0, CURSOR_ADDR};
            `CHTC_MADDR_OFS:
               AVS_READDATA <= {22'h0, MEM_ADDR};
            default:
               AVS_READDATA <= 32'h00000000;
         endcase
      end else begin
         AVS_WAITREQUEST <= 1'b1;
      end
   end

   // key requests; a key also takes the keyboard busy lock
   always @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         mon_r      <= 2'b00;
         allow_r    <= 1'b0;
         brk_r      <= 1'b0;
         home_req_r <= 1'b0;
         clr_req_r  <= 1'b0;
         tab_req_r  <= 1'b0;
         KEYBOARD_BUSY_FLAG <= 1'b0;
      end else if (poc_r) begin
         brk_r      <= ctrl_wr & AVS_WRITEDATA[`CHTC_CTRL_BREAK];
         allow_r    <= ctrl_wr ? AVS_WRITEDATA[`CHTC_CTRL_ALLOW] :
                       allow_r;
         home_req_r <= 1'b0;
         clr_req_r  <= 1'b0;
         tab_req_r  <= 1'b0;
         KEYBOARD_BUSY_FLAG <= 1'b0;
      end else begin
         brk_r <= ctrl_wr & AVS_WRITEDATA[`CHTC_CTRL_BREAK];
         if (ctrl_wr) begin
            mon_r   <= AVS_WRITEDATA[`CHTC_CTRL_MON_HI:`CHTC_CTRL_MON_LO];
            allow_r <= AVS_WRITEDATA[`CHTC_CTRL_ALLOW];
         end
         if (ctrl_wr & AVS_WRITEDATA[`CHTC_CTRL_HOME])
            home_req_r <= 1'b1;
         else if (stb_rise)
            home_req_r <= 1'b0;
         if (ctrl_wr & AVS_WRITEDATA[`CHTC_CTRL_CLEAR])
            clr_req_r <= 1'b1;
         else if (stb_rise)
            clr_req_r <= 1'b0;
         if (ctrl_wr & AVS_WRITEDATA[`CHTC_CTRL_TAB])
            tab_req_r <= 1'b1;
         else if (cur_rise)
            tab_req_r <= 1'b0;
         if (ctrl_wr & (|AVS_WRITEDATA[2:0]))
            KEYBOARD_BUSY_FLAG <= 1'b1;
         else if (clr_go | home_go)
            KEYBOARD_BUSY_FLAG <= 1'b0;
         else if (fet_rise & ~tab_compare_r & ~insert_pending_r &
                  ~newline_insert_r & ~INSERT_EDIT_FLAG)
            KEYBOARD_BUSY_FLAG <= 1'b0;
      end
   end

   // cursor transfer: reset to cleared count, then load address
   always @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         xfer_st_r   <= ST_IDLE;
         CURSOR_ADDR <= `CHTC_CLEARED_CNT;
      end else if (poc_r) begin
         xfer_st_r   <= ST_IDLE;
         CURSOR_ADDR <= `CHTC_CLEARED_CNT;
      end else begin
         case (xfer_st_r)
            ST_IDLE: begin
               if (home_go | clr_go | hit_tab | hit_stop) begin
                  CURSOR_ADDR <= `CHTC_CLEARED_CNT;
                  xfer_st_r   <= ST_XFER;
               end else if (INSERT_EDIT_FLAG & ph4_rise) begin
                  CURSOR_ADDR <= CURSOR_ADDR + 10'h001;
               end
            end
            ST_XFER: begin
               CURSOR_ADDR <= MEM_ADDR;
               xfer_st_r   <= ST_DONE;
            end
            ST_DONE:
               xfer_st_r <= ST_IDLE;
            default:
               xfer_st_r <= ST_IDLE;
         endcase
      end
   end

   // memory address: counter during power-up clear, else rests at base
   always @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         MEM_ADDR            <= 10'h000;
         ADDR_FROM_COUNTER   <= 1'b1;
         MEMORY_CYCLE_LAUNCH <= 1'b1;
         MEMORY_WRITE_DATA_LINES <= 6'h00;
      end else if (poc_r) begin
         MEMORY_CYCLE_LAUNCH <= 1'b1;
         ADDR_FROM_COUNTER   <= 1'b1;
         MEM_ADDR            <= ma_step;
         MEMORY_WRITE_DATA_LINES <=
            (ma_step[0] & ma_step[2]) ? `CHTC_CODE_ES : 6'h00;
      end else begin
         MEMORY_CYCLE_LAUNCH <= EDIT_MEMORY_REQUEST;
         ADDR_FROM_COUNTER   <= 1'b0;
         MEMORY_WRITE_DATA_LINES <= DISPLAY_REG;
         MEM_ADDR <= base_cnt;
      end
   end

   // clear, tab and insert edit flags
   always @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         end_screen_flag_r <= 1'b0;
         one_cycle_edit_r  <= 1'b0;
         tab_compare_r     <= 1'b0;
         insert_pending_r  <= 1'b0;
         newline_insert_r  <= 1'b0;
         arm_end_detect_r  <= 1'b0;
         edit_tab_code_r   <= 1'b1;
         INSERT_EDIT_FLAG  <= 1'b0;
      end else if (poc_r) begin
         end_screen_flag_r <= 1'b0;
         one_cycle_edit_r  <= 1'b0;
         tab_compare_r     <= 1'b0;
         insert_pending_r  <= 1'b0;
         newline_insert_r  <= 1'b0;
         arm_end_detect_r  <= 1'b0;
         edit_tab_code_r   <= 1'b1;
         INSERT_EDIT_FLAG  <= 1'b0;
      end else begin
         if (clr_go) begin
            end_screen_flag_r <= 1'b1;
            one_cycle_edit_r  <= 1'b1;
         end else if (one_cycle_edit_r & ph4_rise) begin
            end_screen_flag_r <= 1'b0;
            one_cycle_edit_r  <= 1'b0;
         end
         if (tab_set & (hp_s1 > `CHTC_HP_LIMIT)) begin
            newline_insert_r <= 1'b1;
            edit_tab_code_r  <= 1'b0;
         end else if (tab_set & ~hp_mod8) begin
            tab_compare_r   <= 1'b1;
            edit_tab_code_r <= 1'b1;
         end else if (hit_tab | hit_stop) begin
            tab_compare_r <= 1'b0;
         end
         if (newline_insert_r & fet_rise & ~insert_pending_r)
            arm_end_detect_r <= 1'b1;
         else if (arm_end_detect_r & (rd_end | rd_nl |
                  (hp_s1 == `CHTC_HP_LAST)))
            arm_end_detect_r <= 1'b0;
         if ((tab_compare_r & (rd_end | rd_nl)) |
             (arm_end_detect_r & rd_end))
            insert_pending_r <= 1'b1;
         else if (insert_pending_r & fet_rise)
            insert_pending_r <= 1'b0;
         if (insert_pending_r & fet_rise)
            INSERT_EDIT_FLAG <= 1'b1;
         else if (INSERT_EDIT_FLAG & ph4_rise) begin
            INSERT_EDIT_FLAG <= 1'b0;
            newline_insert_r <= 1'b0;
         end
      end
   end

   // display register, edit request and strobes to the sequencer
   always @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         DISPLAY_REG           <= 6'h00;
         EDIT_MEMORY_REQUEST   <= 1'b0;
         DISPLAY_REG_TO_MEMORY <= 1'b1;
         HORIZONTAL_JUMP_EIGHT <= 1'b0;
      end else if (poc_r) begin
         DISPLAY_REG           <= 6'h00;
         EDIT_MEMORY_REQUEST   <= 1'b0;
         DISPLAY_REG_TO_MEMORY <= 1'b1;
         HORIZONTAL_JUMP_EIGHT <= 1'b0;
      end else begin
         EDIT_MEMORY_REQUEST <= (one_cycle_edit_r |
                                 INSERT_EDIT_FLAG) & ~ph4_rise;
         DISPLAY_REG_TO_MEMORY <= 1'b1;
         // input lines latched at phase one
         if (ph1_rise & one_cycle_edit_r & end_screen_flag_r)
            DISPLAY_REG <= `CHTC_CODE_ES;
         else if (ph1_rise & INSERT_EDIT_FLAG)
            DISPLAY_REG <= edit_tab_code_r ? `CHTC_CODE_FT :
                                             `CHTC_CODE_NL;
         HORIZONTAL_JUMP_EIGHT <= rd_ft & (hp_next8 <= `CHTC_HP_LAST);
      end
   end
endmodule
`default_nettype wire

// file: rtl/chtc_regs.vh
`ifndef CHTC_REGS_VH
`define CHTC_REGS_VH
// avalon register byte offsets
`define CHTC_CTRL_OFS     4'h0
`define CHTC_STAT_OFS     4'h4
`define CHTC_CURSOR_OFS   4'h8
`define CHTC_MADDR_OFS    4'hc
// control register bits (write one to request home, clear, tab; allow and monitor bits are written as values)
`define CHTC_CTRL_HOME    0
`define CHTC_CTRL_CLEAR   1
`define CHTC_CTRL_TAB     2
`define CHTC_CTRL_ALLOW   3
`define CHTC_CTRL_BREAK   4
`define CHTC_CTRL_MON_LO  8
`define CHTC_CTRL_MON_HI  9
// status register bits
`define CHTC_STAT_POC     0
`define CHTC_STAT_BUSY    1
`define CHTC_STAT_EDIT    2
`define CHTC_STAT_TABC    3
`define CHTC_STAT_INS     4
`define CHTC_STAT_NLC     5
`define CHTC_STAT_ARM     6
// screen geometry and counts
`define CHTC_CLEARED_CNT  10'h005
`define CHTC_SCREEN_SPAN  10'h100
`define CHTC_HP_LIMIT     7'h48
`define CHTC_HP_LAST      7'h4f
`define CHTC_POC_CYCLES   20'h00100
// character codes, arbitrary
`define CHTC_CODE_ES      6'h3f
`define CHTC_CODE_NL      6'h3e
`define CHTC_CODE_FT      6'h3d
`endif
